//--- common/acs_pkg.sv
package acs_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0]  A_CTRL = 8'h00;
  localparam logic [7:0]  A_OFFS = 8'h04;
  localparam logic [7:0]  A_GAIN = 8'h08;
  localparam logic [7:0]  A_DATA = 8'h0c;
  localparam logic [7:0]  A_STAT = 8'h10;
  // control fields
  localparam int          F_MODE = 0;
  localparam int          F_BIP  = 3;
  localparam int          F_CHAN = 4;
  localparam int          F_PGA  = 6;
  localparam int          F_W24  = 9;
  localparam logic [9:0]  CTRL_RST = 10'h200;
  localparam logic [24:0] OFFS_RST = 25'h0000000;
  localparam logic [25:0] GAIN_RST = 26'h0400000;
  // ****************************************
  // codes
  // ****************************************
  localparam logic [2:0]  MD_SELF = 3'h1;
  localparam logic [2:0]  MD_SYS0 = 3'h2;
  localparam logic [2:0]  MD_SYS1 = 3'h3;
  localparam logic [2:0]  MD_SOFF = 3'h4;
  localparam logic [2:0]  MD_BG   = 3'h5;
  localparam logic [1:0]  ND_AIN   = 2'h0;
  localparam logic [1:0]  ND_SHORT = 2'h1;
  localparam logic [1:0]  ND_REF   = 2'h2;
  localparam logic [1:0]  CH_HL    = 2'h2;
  // ****************************************
  // counts, in output-rate periods; DIV_LAST in clock cycles
  // ****************************************
  localparam logic [3:0]  N_SELF_PH = 4'h3;
  localparam logic [3:0]  N_SYS_PH  = 4'h3;
  localparam logic [3:0]  N_SETL_SELF = 4'h3;
  localparam logic [3:0]  N_SETL_SYS  = 4'h1;
  localparam logic [2:0]  BG_LAST = 3'h5;
  localparam logic [5:0]  DIV_LAST = 6'h2f;
  // ****************************************
  // arithmetic
  // ****************************************
  localparam int          GAIN_FRAC = 22;
  localparam logic [25:0] TGT_UNI = 26'h0ffffff;
  localparam logic [25:0] TGT_BIP = 26'h07fffff;
  localparam logic [32:0] MID     = 33'h000800000;
  localparam logic [32:0] FS_MAX  = 33'h000ffffff;
  localparam logic [24:0] SPAN_MIN_DIFF = 25'h0333333;
  localparam logic [24:0] SPAN_MAX_DIFF = 25'h0866666;
  localparam logic [24:0] SPAN_MIN_HL   = 25'h0333333;
  localparam logic [24:0] SPAN_MAX_HL   = 25'h0433333;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_ZERO = 6'b000010,
    ST_FULL = 6'b000100,
    ST_DIV  = 6'b001000,
    ST_SETL = 6'b010000,
    ST_BG   = 6'b100000
  } acs_state_t;

  typedef struct packed {
    logic [1:0] node;
    logic [1:0] chan;
    logic [2:0] pga;
    logic       bipolar;
    logic       filt_rst;
  } acs_fe_t;
endpackage

//--- src/acs_cal_seq.sv
`timescale 1ns/1ps
// Functional notes
// RL1 - corrections run at 33 bits, result delivered as 24 or 16 bits
// RL2 - correction subtracts offset first, then multiplies by full-scale coefficient
// RL3 - host may write offset and full-scale coefficients directly
// RL4 - ready output goes high one cycle after a calibration command, low on completion
// RL5 - host ignores ready for one modulator cycle after a calibration command
// RL6 - mode 001 converts shorted node, then reference, settles, then signals ready
// RL7 - self calibration runs at the selected gain setting
// RL8 - bipolar self calibration spans midscale to positive full scale
// RL9 - mode 010 captures input as zero point, then signals ready
// RL10 - mode 011 captures input as full scale, derives slope, signals ready
// RL11 - system holds calibration voltage steady during each system step
// RL12 - mode 010 after a full system calibration keeps the slope
// RL13 - mode 100 zero from input, span against reference, one step
// RL14 - system calibrations span endpoints unipolar, midscale to full scale bipolar
// RL15 - mode 101 interleaves calibration with conversions, output rate cut by six
// RL16 - background mode stays until the mode bits change
// RL17 - first background output flagged invalid
// RL18 - valid data after 9, 4, 4, 9 and 6 output periods
// RL19 - system span accepted only within channel limits
// RL20 - system keeps offset plus span within input range; not checked, span_ok tests only the span window
// RL21 - every calibration command resets the filter first
// RL22 - one polarity bit sets coding of both differential channels
// RL23 - high-level channel is always unipolar
// RL24 - other mode codes start nothing and keep coefficients
module acs_cal_seq (
  // apb
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  // filter samples
  input  wire logic [24:0]     raw_sample,
  input  wire logic            raw_valid,
  // front end and pin
  output acs_pkg::acs_fe_t     fe,
  output logic                 result_ready_n
);
  import acs_pkg::*;

  acs_state_t         state_ff, nxt_state;
  logic [9:0]         ctrl_ff, nxt_ctrl;
  logic [2:0]         run_ff, nxt_run, slot_ff, nxt_slot;
  logic [3:0]         cnt_ff, nxt_cnt;
  logic [24:0]        zs_ff, nxt_zs, offs_ff, nxt_offs;
  logic [25:0]        gain_ff, nxt_gain;
  logic [23:0]        data_ff, nxt_data;
  logic [31:0]        prdata_ff, nxt_prdata;
  logic [1:0]         node_ff, nxt_node;
  logic               rdyn_ff, nxt_rdyn, frst_ff, nxt_frst;
  logic               err_ff, nxt_err, bgf_ff, nxt_bgf, inval_ff, nxt_inval;
  logic [47:0]        dvd_ff, nxt_dvd;
  logic [25:0]        rem_ff, nxt_rem;
  logic [24:0]        den_ff, nxt_den, div_den, span_c, base_c;
  logic [5:0]         dcnt_ff, nxt_dcnt;
  logic               dbusy_ff, nxt_dbusy, done_ff, nxt_done, div_go;
  logic [25:0]        div_tgt, quo, r_try;
  logic signed [25:0] diff;
  logic signed [52:0] prod;
  logic signed [32:0] wide, res;
  logic [23:0]        out24;
  logic [3:0]         ph_len, st_len;
  logic               wr, rd, cwr, hit, bip_eff, cal_code, span_ok, smp;

  // ****************************************
  // apb decode
  // ****************************************
  assign wr      = psel && penable && pwrite;
  assign rd      = psel && penable && !pwrite;
  assign cwr     = wr && (paddr == A_CTRL);
  // RL21 drop sample from before filter reset
  assign smp     = raw_valid && !frst_ff;
  assign hit     = (paddr == A_CTRL) || (paddr == A_OFFS) || (paddr == A_GAIN) ||
                   (paddr == A_DATA) || (paddr == A_STAT);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata  = prdata_ff;
  assign result_ready_n = rdyn_ff;
  assign fe = '{node: node_ff, chan: ctrl_ff[F_CHAN +: 2], pga: ctrl_ff[F_PGA +: 3],
                bipolar: bip_eff, filt_rst: frst_ff};
  assign cal_code = (pwdata[2:0] >= MD_SELF) && (pwdata[2:0] <= MD_BG);

  // RL22 RL23 coding select
  assign bip_eff = ctrl_ff[F_BIP] && (ctrl_ff[F_CHAN +: 2] != CH_HL);

  // ****************************************
  // correction path
  // ****************************************
  // RL2 subtract then scale
  assign diff = $signed({raw_sample[24], raw_sample}) - $signed({offs_ff[24], offs_ff});
  assign prod = diff * $signed({1'b0, gain_ff});
  // RL1 33-bit internal result
  assign wide = $signed({{2{prod[52]}}, prod[52:GAIN_FRAC]});
  assign res  = bip_eff ? wide + $signed(MID) : wide;
  assign out24 = res[32] ? 24'h000000 : (res > $signed(FS_MAX)) ? 24'hffffff : res[23:0];

  // ****************************************
  // calibration helpers
  // ****************************************
  assign base_c = (run_ff == MD_SYS1) ? offs_ff : zs_ff;
  assign span_c = raw_sample - base_c;
  // RL8 RL14 span target
  assign div_tgt = bip_eff ? TGT_BIP : TGT_UNI;
  // RL19 span window
  assign span_ok = (ctrl_ff[F_CHAN +: 2] == CH_HL) ?
                   (span_c >= SPAN_MIN_HL && span_c <= SPAN_MAX_HL) :
                   (span_c >= SPAN_MIN_DIFF && span_c <= SPAN_MAX_DIFF);
  // RL18 step lengths
  assign ph_len = (run_ff == MD_SELF || run_ff == MD_SOFF) ? N_SELF_PH : N_SYS_PH;
  assign st_len = (run_ff == MD_SELF || run_ff == MD_SOFF) ? N_SETL_SELF : N_SETL_SYS;
  assign quo = (|dvd_ff[47:26]) ? 26'h3ffffff : dvd_ff[25:0];

  // ****************************************
  // sequencer and registers
  // ****************************************
  always_comb begin
    nxt_state = state_ff;
    nxt_ctrl  = ctrl_ff;
    nxt_run   = run_ff;
    nxt_slot  = slot_ff;
    nxt_cnt   = cnt_ff;
    nxt_zs    = zs_ff;
    nxt_offs  = offs_ff;
    nxt_gain  = gain_ff;
    nxt_data  = data_ff;
    nxt_rdyn  = rdyn_ff;
    nxt_frst  = 1'b0;
    nxt_err   = err_ff;
    nxt_bgf   = bgf_ff;
    nxt_inval = inval_ff;
    div_go    = 1'b0;
    div_den   = span_c;
    // RL3 direct coefficient writes
    if (wr && paddr == A_OFFS) begin
      nxt_offs = pwdata[24:0];
    end
    if (wr && paddr == A_GAIN) begin
      nxt_gain = pwdata[25:0];
    end
    if (rd && paddr == A_DATA) begin
      nxt_rdyn = 1'b1;
    end
    if (done_ff && (state_ff == ST_DIV || state_ff == ST_BG)) begin
      nxt_gain = quo;
    end
    unique case (state_ff)
      ST_IDLE: begin
        if (raw_valid) begin
          nxt_data = out24;
          nxt_rdyn = 1'b0;
        end
      end
      ST_ZERO: begin
        if (smp) begin
          nxt_cnt = cnt_ff + 4'h1;
          if (cnt_ff == ph_len - 4'h1) begin
            // RL9 RL6 zero capture
            nxt_zs    = raw_sample;
            nxt_offs  = raw_sample;
            nxt_cnt   = 4'h0;
            // RL12 offset only
            nxt_state = (run_ff == MD_SYS0) ? ST_SETL : ST_FULL;
          end
        end
      end
      ST_FULL: begin
        if (smp) begin
          nxt_cnt = cnt_ff + 4'h1;
          if (cnt_ff == ph_len - 4'h1) begin
            nxt_cnt = 4'h0;
            // RL10 RL13 slope from span
            if (span_ok || run_ff == MD_SELF) begin
              div_go    = 1'b1;
              nxt_state = ST_DIV;
            end else begin
              nxt_err   = 1'b1;
              nxt_state = ST_SETL;
            end
          end
        end
      end
      ST_DIV: begin
        if (done_ff) begin
          nxt_state = ST_SETL;
        end
      end
      ST_SETL: begin
        if (smp) begin
          nxt_cnt = cnt_ff + 4'h1;
          if (cnt_ff == st_len - 4'h1) begin
            // RL4 RL6 completion
            nxt_data  = out24;
            nxt_rdyn  = 1'b0;
            nxt_cnt   = 4'h0;
            nxt_state = ST_IDLE;
          end
        end
      end
      ST_BG: begin
        if (smp) begin
          // RL15 six-slot interleave
          nxt_slot = (slot_ff == BG_LAST) ? 3'h0 : slot_ff + 3'h1;
          if (slot_ff == 3'h0) begin
            nxt_zs   = raw_sample;
            nxt_offs = raw_sample;
          end else if (slot_ff == 3'h1) begin
            div_go = 1'b1;
          end else if (slot_ff == BG_LAST) begin
            nxt_data  = out24;
            nxt_rdyn  = 1'b0;
            // RL17 first output flagged
            nxt_inval = bgf_ff;
            nxt_bgf   = 1'b0;
          end
        end
      end
    endcase
    if (cwr) begin
      nxt_ctrl = pwdata[9:0];
      if (cal_code) begin
        // RL21 RL4 filter reset, busy
        nxt_frst  = 1'b1;
        nxt_rdyn  = 1'b1;
        nxt_run   = pwdata[2:0];
        nxt_cnt   = 4'h0;
        nxt_slot  = 3'h0;
        nxt_err   = 1'b0;
        nxt_bgf   = 1'b1;
        nxt_inval = 1'b0;
        nxt_state = (pwdata[2:0] == MD_BG) ? ST_BG :
                    (pwdata[2:0] == MD_SYS1) ? ST_FULL : ST_ZERO;
      end else if (state_ff == ST_BG) begin
        // RL16 RL24 leave background only
        nxt_state = ST_IDLE;
      end
    end
    // RL6 RL7 RL13 node select
    nxt_node = ND_AIN;
    if (nxt_state == ST_BG) begin
      nxt_node = (nxt_slot == 3'h0) ? ND_SHORT : (nxt_slot == 3'h1) ? ND_REF : ND_AIN;
    end else if (nxt_state == ST_ZERO && nxt_run == MD_SELF) begin
      nxt_node = ND_SHORT;
    end else if (nxt_state == ST_FULL && nxt_run != MD_SYS1) begin
      nxt_node = ND_REF;
    end
    nxt_prdata = 32'h00000000;
    if (psel && !penable) begin
      unique case (paddr)
        A_CTRL:  nxt_prdata = {22'h000000, ctrl_ff};
        A_OFFS:  nxt_prdata = {{7{offs_ff[24]}}, offs_ff};
        A_GAIN:  nxt_prdata = {6'h00, gain_ff};
        A_DATA:  nxt_prdata = ctrl_ff[F_W24] ? {8'h00, data_ff} : {16'h0000, data_ff[23:8]};
        A_STAT:  nxt_prdata = {27'h0000000, state_ff == ST_BG, inval_ff, err_ff,
                               !rdyn_ff, !(state_ff == ST_IDLE || state_ff == ST_BG)};
        default: nxt_prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff  <= ST_IDLE;
      ctrl_ff   <= CTRL_RST;
      run_ff    <= 3'h0;
      slot_ff   <= 3'h0;
      cnt_ff    <= 4'h0;
      zs_ff     <= OFFS_RST;
      offs_ff   <= OFFS_RST;
      gain_ff   <= GAIN_RST;
      data_ff   <= 24'h000000;
      rdyn_ff   <= 1'b1;
      frst_ff   <= 1'b0;
      err_ff    <= 1'b0;
      bgf_ff    <= 1'b0;
      inval_ff  <= 1'b0;
      node_ff   <= ND_AIN;
      prdata_ff <= 32'h00000000;
    end else begin
      state_ff  <= nxt_state;
      ctrl_ff   <= nxt_ctrl;
      run_ff    <= nxt_run;
      slot_ff   <= nxt_slot;
      cnt_ff    <= nxt_cnt;
      zs_ff     <= nxt_zs;
      offs_ff   <= nxt_offs;
      gain_ff   <= nxt_gain;
      data_ff   <= nxt_data;
      rdyn_ff   <= nxt_rdyn;
      frst_ff   <= nxt_frst;
      err_ff    <= nxt_err;
      bgf_ff    <= nxt_bgf;
      inval_ff  <= nxt_inval;
      node_ff   <= nxt_node;
      prdata_ff <= nxt_prdata;
    end
  end

  // ****************************************
  // gain divider
  // ****************************************
  assign r_try = {rem_ff[24:0], dvd_ff[47]};
  always_comb begin
    nxt_dvd   = dvd_ff;
    nxt_rem   = rem_ff;
    nxt_den   = den_ff;
    nxt_dcnt  = dcnt_ff;
    nxt_dbusy = dbusy_ff;
    nxt_done  = 1'b0;
    if (div_go) begin
      nxt_dvd   = {div_tgt[25:0], 22'h000000};
      nxt_rem   = 26'h0000000;
      nxt_den   = div_den;
      nxt_dcnt  = 6'h00;
      nxt_dbusy = 1'b1;
    end else if (dbusy_ff) begin
      if (r_try >= {1'b0, den_ff}) begin
        nxt_rem = r_try - {1'b0, den_ff};
        nxt_dvd = {dvd_ff[46:0], 1'b1};
      end else begin
        nxt_rem = r_try;
        nxt_dvd = {dvd_ff[46:0], 1'b0};
      end
      nxt_dcnt = dcnt_ff + 6'h01;
      if (dcnt_ff == DIV_LAST) begin
        nxt_dbusy = 1'b0;
        nxt_done  = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dvd_ff   <= 48'h000000000000;
      rem_ff   <= 26'h0000000;
      den_ff   <= 25'h0000000;
      dcnt_ff  <= 6'h00;
      dbusy_ff <= 1'b0;
      done_ff  <= 1'b0;
    end else begin
      dvd_ff   <= nxt_dvd;
      rem_ff   <= nxt_rem;
      den_ff   <= nxt_den;
      dcnt_ff  <= nxt_dcnt;
      dbusy_ff <= nxt_dbusy;
      done_ff  <= nxt_done;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_start;
    cwr && cal_code;
  endsequence
  sequence s_busy;
    result_ready_n && fe.filt_rst ##1 !fe.filt_rst && result_ready_n;
  endsequence
  sequence s_last_settle;
    state_ff == ST_SETL && raw_valid && cnt_ff == st_len - 4'h1 && !cwr;
  endsequence

  AST_CAL_START: assert property (s_start |=> s_busy) // RL4
    else $error("calibration start not flagged");
  AST_CAL_DONE: assert property (s_last_settle |=> state_ff == ST_IDLE && !result_ready_n) // RL6
    else $error("calibration did not complete");
  AST_SYS0_SLOPE: assert property ((state_ff == ST_ZERO && run_ff == MD_SYS0
      && !(wr && paddr == A_GAIN)) |=> $stable(gain_ff)) // RL12
    else $error("offset step altered slope");
  AST_BAD_MODE: assert property ((cwr && !cal_code && state_ff == ST_IDLE
      && !raw_valid) |=> state_ff == ST_IDLE && $stable(gain_ff)) // RL24
    else $error("unlisted mode started a sequence");
  AST_BG_STAY: assert property ((state_ff == ST_BG && !cwr) |=> state_ff == ST_BG) // RL16
    else $error("background mode left without mode change");
  AST_BG_RATE: assert property ((state_ff == ST_BG && raw_valid && slot_ff != BG_LAST
      && !cwr && result_ready_n) |=> result_ready_n) // RL15
    else $error("background output outside its slot");
  AST_ZERO_RESULT: assert property ((state_ff == ST_IDLE && raw_valid && !cwr
      && raw_sample == offs_ff && !bip_eff) |=> data_ff == 24'h000000) // RL2
    else $error("offset not subtracted");
  AST_HL_UNI: assert property ((ctrl_ff[F_CHAN +: 2] == CH_HL) |-> !fe.bipolar) // RL23
    else $error("high-level channel coded bipolar");
  AST_SYS1_NODE: assert property ((state_ff == ST_FULL && run_ff == MD_SYS1)
      |-> fe.node == ND_AIN) // RL10
    else $error("full-scale step not on input");
endmodule

//--- test/acs_fe_model.sv
`timescale 1ns/1ps
module acs_fe_model #(
  parameter int          PER     = 100,
  parameter logic [24:0] S_SHORT = 25'h0000123,
  parameter logic [24:0] S_REF   = 25'h0400000
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // front end select and analog input
  input  wire acs_pkg::acs_fe_t fe,
  input  wire logic [24:0]      ain,
  // filter samples
  output logic      [24:0]      raw_sample,
  output logic                  raw_valid
);
  import acs_pkg::*;
  int          cnt;
  logic [24:0] val;
  assign val = (fe.node == ND_SHORT) ? S_SHORT : (fe.node == ND_REF) ? S_REF : ain;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      raw_valid <= 1'b0;
      raw_sample <= 25'h0;
    end else begin
      cnt <= (fe.filt_rst || cnt == PER - 1) ? 0 : cnt + 1;
      raw_valid <= (cnt == PER - 1) && !fe.filt_rst;
      raw_sample <= (cnt == PER - 1) ? val : ~raw_sample;
    end
  end
endmodule

//--- test/tb_adc_calibration_sequencer.sv
`timescale 1ns/1ps
module tb_adc_calibration_sequencer;
  import acs_pkg::*;
  localparam logic [24:0] S_SHORT = 25'h0000123;
  typedef struct {string nm; logic [31:0] d; logic e;} acs_note_t;
  logic             pclk    = 1'b0;
  logic             presetn = 1'b0;
  logic             psel    = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite  = 1'b0;
  logic [7:0]       paddr   = 8'h00;
  logic [31:0]      pwdata  = 32'h0;
  logic [24:0]      ain     = 25'h0;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic [24:0]      raw_sample;
  logic             raw_valid;
  logic             result_ready_n;
  acs_fe_t          fe;
  acs_note_t        q[$];
  acs_note_t        mn;
  int               err_total  = 0;
  int               n_compared = 0;
  int               cyc        = 0;
  logic [15:0]      seed       = 16'h000e;

  always #2.5 pclk = ~pclk;

  acs_cal_seq acs_cal_seq_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .raw_sample(raw_sample),
    .raw_valid(raw_valid), .fe(fe), .result_ready_n(result_ready_n));
  acs_fe_model #(.PER(100), .S_SHORT(S_SHORT)) acs_fe_model_inst (.pclk(pclk),
    .presetn(presetn), .fe(fe), .ain(ain), .raw_sample(raw_sample), .raw_valid(raw_valid));

  // ****************************************
  // checking and closing
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      summarize();
    end
  end

  // read monitor takes oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && q.size() > 0) begin
      mn = q.pop_front();
      chk(mn.nm, prdata, mn.d);
      chk({mn.nm, " err"}, {31'h0, pslverr}, {31'h0, mn.e});
    end
  end

  // ****************************************
  // drivers
  // ****************************************
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e,
                    input logic er = 1'b0);
    q.push_back('{nm, e, er});
    xfer(1'b0, a, 32'h0);
  endtask

  task automatic settle(output int np);
    np = 0;
    repeat (3000) begin
      @(posedge pclk);
      if (result_ready_n === 1'b0) break;
      if (raw_valid === 1'b1) np++;
    end
  endtask

  task automatic cal(input logic [9:0] c, input int exp_n);
    int np;
    settle(np);
    xfer(1'b1, A_CTRL, {22'h0, c});
    chk("ready_n start", {31'h0, result_ready_n}, 32'h1);
    chk("filt_rst", {31'h0, fe.filt_rst}, 32'h1);
    rd("stat busy", A_STAT, (c[2:0] == MD_BG) ? 32'h10 : 32'h1);
    settle(np);
    chk("periods", 32'(np), 32'(exp_n));
  endtask

  function automatic logic [31:0] corr(input longint r, input longint o, input longint g,
                                        input bit b);
    longint v;
    v = ((r - o) * g) >>> 22;
    if (b) v = v + 'h800000;
    if (v < 0) v = 0;
    if (v > 'hffffff) v = 'hffffff;
    return 32'(v);
  endfunction

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    int np;
    logic [31:0] ev;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd("ctrl", A_CTRL, 32'h200);
    rd("offs", A_OFFS, 32'h0);
    rd("gain", A_GAIN, 32'h400000);
    rd("unmapped", 8'h20, 32'h0, 1'b1);
    $display("reset test done");
    xfer(1'b1, A_OFFS, 32'h100);
    xfer(1'b1, A_GAIN, 32'h200000);
    rd("offs wr", A_OFFS, 32'h100);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      xfer(1'b1, A_CTRL, ((i < 2) ? 32'h200 : 32'h0) | (32'(i % 2) << 3));
      ain <= (i == 0) ? 25'h100 : {9'h0, seed};
      xfer(1'b0, A_DATA, 32'h0);
      settle(np);
      ev = corr((i == 0) ? 'h100 : longint'(seed), 'h100, 'h200000, i % 2);
      rd("data", A_DATA, (i < 2) ? ev : ev >> 8);
    end
    for (int c = 0; c < 3; c++) begin
      xfer(1'b1, A_CTRL, 32'h200 | 32'h8 | (32'(c) << 4) | (32'h5 << 6));
      chk("chan", {30'h0, fe.chan}, 32'(c));
      chk("pga", {29'h0, fe.pga}, 32'h5);
      chk("bipolar", {31'h0, fe.bipolar}, 32'(c != 2));
    end
    $display("correction test done");
    cal(10'h201, 9);
    rd("offs self", A_OFFS, {7'h0, S_SHORT});
    rd("stat self", A_STAT, 32'h2);
    xfer(1'b1, A_GAIN, 32'h3a0000);
    ain <= 25'h40;
    cal(10'h202, 4);
    rd("offs sys0", A_OFFS, 32'h40);
    rd("gain sys0", A_GAIN, 32'h3a0000);
    ain <= 25'h400040;
    cal(10'h20b, 4);
    rd("stat sys1", A_STAT, 32'h2);
    rd("gain sys1", A_GAIN, 32'h7fffff);
    rd("offs sys1", A_OFFS, 32'h40);
    ain <= 25'h20;
    cal(10'h204, 9);
    rd("offs soff", A_OFFS, 32'h20);
    $display("calibration test done");
    xfer(1'b1, A_GAIN, 32'h3b0000);
    for (int m = 0; m < 3; m++) begin
      xfer(1'b1, A_CTRL, 32'h200 | ((m == 0) ? 32'h0 : 32'(m + 5)));
      chk("no filt_rst", {31'h0, fe.filt_rst}, 32'h0);
      rd("offs kept", A_OFFS, 32'h20);
      rd("gain kept", A_GAIN, 32'h3b0000);
    end
    $display("unlisted mode test done");
    cal(10'h205, 6);
    rd("stat bg", A_STAT, 32'h1a);
    for (int k = 0; k < 2; k++) begin
      xfer(1'b0, A_DATA, 32'h0);
      settle(np);
      chk("bg rate", 32'(np), 32'h6);
    end
    xfer(1'b1, A_CTRL, 32'h200);
    xfer(1'b0, A_DATA, 32'h0);
    settle(np);
    chk("normal rate", 32'(np), 32'h1);
    $display("background test done");
    xfer(1'b1, A_GAIN, 32'h3c0000);
    ain <= 25'h100040;
    cal(10'h203, 4);
    rd("stat span", A_STAT, 32'h6);
    rd("gain span", A_GAIN, 32'h3c0000);
    $display("span test done");
    summarize();
  end
endmodule
